/* File: bench/lane_checker_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module lane_checker #(
    parameter int NLANES = 4
) (
    input wire logic              aclk,
    input wire logic              aresetn,
    input wire logic              s_axi_awvalid,
    input wire logic              s_axi_awready,
    input wire logic              s_axi_wvalid,
    input wire logic              s_axi_wready,
    input wire logic              s_axi_bvalid,
    input wire logic [7:0]        s_axi_araddr,
    input wire logic              s_axi_arvalid,
    input wire logic              s_axi_arready,
    input wire logic [31:0]       s_axi_rdata,
    input wire logic [1:0]        s_axi_rresp,
    input wire logic              s_axi_rvalid,
    input wire logic              rx_path_reset,
    input wire logic              tx_output_inhibit,
    input wire logic              lane_sleep,
    input wire logic              rx_valid,
    input wire logic              serial_out_pos,
    input wire logic              serial_out_oe,
    input wire logic [NLANES-1:0] bond_found,
    input wire logic              lane_aligned
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // line side quiet states and alignment
    inhibit_low_a: assert property (
        $past(tx_output_inhibit) |-> !serial_out_pos)
        else $error("pos high inhibited");
    sleep_quiet_a: assert property (
        lane_sleep [*2] |-> !serial_out_oe && !rx_valid)
        else $error("awake in sleep");
    rx_hold_a: assert property (
        rx_path_reset [*6] |-> !rx_valid && bond_found == '0)
        else $error("rx state kept");
    rx_release_a: assert property (
        rx_path_reset [*6] ##1 !rx_path_reset |-> (!rx_valid) [*5])
        else $error("rx out early");
    aligned_found_a: assert property (
        lane_aligned |-> &bond_found)
        else $error("aligned unfound");
    // register bus answers
    write_resp_a: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid)
        else $error("no write resp");
    read_answer_a: assert property (
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    unmapped_err_a: assert property (
        s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h14
        |=> s_axi_rresp == 2'b10 && s_axi_rdata == '0)
        else $error("unmapped read ok");
endmodule
bind serdes_lane_pcs lane_checker #(.NLANES(NLANES)) u_chk (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .rx_path_reset, .tx_output_inhibit, .lane_sleep, .rx_valid,
    .serial_out_pos, .serial_out_oe, .bond_found, .lane_aligned
);
`default_nettype wire

/* File: bench/remote_lanes.sv */
`timescale 1ns/1ps
`default_nettype none
module remote_lanes #(
    parameter int NLANES = 4
) (
    input wire logic          aclk,
    input wire logic [7:0]    bond_char,
    output logic [8*NLANES-1:0] lane_bytes,
    output logic              lane_valid
);
    logic [7:0] word_ff = 8'h00;
    assign lane_valid = 1'b1;
    // lane i lags i words; bond char every 16, top bit clear
    always_ff @(posedge aclk) begin
        word_ff <= word_ff + 8'h01;
        for (int i = 0; i < NLANES; i++) begin
            lane_bytes[8*i +: 8] <= ((word_ff - 8'(i)) & 8'h0F) == 8'h00 ?
                bond_char : {1'b0, word_ff[6:0] - 7'(i)};
        end
    end
endmodule
`default_nettype wire

/* File: bench/serdes_pcs_bonding_reset_loopback_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
module serdes_pcs_bonding_reset_loopback_tb_top;
    import lane_pkg::*;
    localparam logic [31:0] MASKS [6] = '{32'h0000_033F, 32'h0,
        32'h0000_00FF, 32'h0, 32'h0, 32'h0000_00FF};
    logic        aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0;
    logic        s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, tx_valid = 1'b0;
    logic        tx_path_reset = 1'b0, rx_path_reset = 1'b0, lane_sleep = 1'b0;
    logic        tx_output_inhibit = 1'b0, lane_rx_valid, lane_aligned;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic        s_axi_rvalid, rx_valid, serial_out_pos, serial_out_oe;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, lfsr = 8'h5A;
    logic [7:0]  bond_char = BOND_RESET, serial_out_byte, v;
    logic [31:0] s_axi_wdata = '0, tx_data = '0, s_axi_rdata, rx_data, d;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic [3:0]  bond_found;
    logic [31:0] lane_rx_bytes;
    logic [31:0] model [6] = '{CTRL_RESET, 32'h0, 32'(BOND_RESET), 32'h0,
        32'h0, 32'(CCHAR_RESET)};
    int          mismatches = 0, comparisons = 0;

    serdes_lane_pcs #(.NLANES(4)) dut (.aclk, .aresetn, .s_axi_awaddr,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .tx_path_reset, .rx_path_reset, .tx_output_inhibit, .lane_sleep,
        .tx_data, .tx_valid, .rx_data, .rx_valid, .lane_rx_bytes,
        .lane_rx_valid, .serial_out_byte, .serial_out_pos,
        .serial_out_neg(), .serial_out_oe, .bond_found, .lane_aligned);
    remote_lanes #(.NLANES(4)) far (.aclk, .bond_char,
        .lane_bytes(lane_rx_bytes), .lane_valid(lane_rx_valid));

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    task automatic check(input string what, input logic [31:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        $display("mismatches %0d comparisons %0d", mismatches, comparisons);
        if (mismatches == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // bus write; ready sampled mid-cycle, released on the edge
    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        logic aw, w, b;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= wd;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            {aw, w, b} = {s_axi_awready, s_axi_wready, s_axi_bvalid};
            r = s_axi_bresp;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (!b);
        s_axi_bready <= 1'b0;
        check("bresp", 32'(r), a > ADDR_CCHAR ? 32'h2 : 32'h0);
        if (a <= ADDR_CCHAR) model[a[4:2]] = wd;
    endtask
    task automatic rd(input logic [7:0] a);
        logic aw, b;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            {aw, b} = {s_axi_arready, s_axi_rvalid};
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (aw) s_axi_arvalid <= 1'b0;
        end while (!b);
        s_axi_rready <= 1'b0;
    endtask
    // read back against model
    task automatic rchk(input logic [7:0] a);
        logic bad;
        bad = a > ADDR_CCHAR;
        rd(a);
        check("rdata", d & (bad ? '1 : MASKS[a[4:2]]),
            bad ? 32'h0 : model[a[4:2]] & MASKS[a[4:2]]);
        check("rresp", 32'(r), bad ? 32'h2 : 32'h0);
    endtask
    task automatic wait_hi(ref logic s);
        for (int n = 0; n < 64 && s !== 1'b1; n++) @(posedge aclk);
    endtask

    initial forever #4 aclk = ~aclk;
    // random tx words, same clock as the lane
    always @(posedge aclk) begin
        lfsr <= lfsr_next(lfsr);
        tx_data <= {4{lfsr}};
        tx_valid <= aresetn;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 7; i++) rchk(8'(4 * i));
        v = {1'b1, lfsr[6:0]};
        bond_char <= v;
        wr(ADDR_BONDCH, 32'(v));
        wr(8'h18, 32'h0000_FFFF);
        rchk(ADDR_BONDCH);
        // each loopback mode
        for (int m = 0; m < 5; m++) begin
            wr(ADDR_CTRL, 32'(m) | (32'(m % 3) << CTRL_WIDTH_LSB));
            repeat (3) @(posedge aclk);
            check("oe", 32'(serial_out_oe), 32'(m != 1));
            rchk(ADDR_CTRL);
        end
        wr(ADDR_CTRL, 32'h0000_0003);
        tx_output_inhibit <= 1'b1;
        repeat (3) @(posedge aclk);
        check("pos", 32'(serial_out_pos), 32'h0);
        check("oe", 32'(serial_out_oe), 32'h1);
        tx_output_inhibit <= 1'b0;
        wr(ADDR_CTRL, 32'h0000_0000);
        lane_sleep <= 1'b1;
        repeat (3) @(posedge aclk);
        check("sleep", {serial_out_oe, rx_valid}, 32'h0);
        lane_sleep <= 1'b0;
        tx_path_reset <= 1'b1;
        repeat (8) @(posedge aclk);
        check("txbyte", 32'(serial_out_byte), 32'h0);
        tx_path_reset <= 1'b0;
        rx_path_reset <= 1'b1;
        repeat (8) @(posedge aclk);
        check("rx_path_reset", {bond_found, rx_valid}, 32'h0);
        rx_path_reset <= 1'b0;
        repeat (5) @(posedge aclk);
        check("rxearly", 32'(rx_valid), 32'h0);
        wait_hi(rx_valid);
        check("rxvalid", 32'(rx_valid), 32'h1);
        repeat (40) @(posedge aclk);
        check("found", 32'(bond_found), 32'hF);
        wr(ADDR_CTRL, 32'h0000_1060);
        wait_hi(lane_aligned);
        check("aligned", 32'(lane_aligned), 32'h1);
        for (int i = 0; i < 20; i++) begin
            @(posedge aclk);
            check("lanes", rx_data, {4{rx_data[7:0]}});
        end
        rd(ADDR_STATUS);
        check("status", d & 32'h7, 32'h4);
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* File: common/lane_pkg.sv */
package lane_pkg;
    // register byte addresses
    localparam logic [7:0] ADDR_CTRL    = 8'h00;
    localparam logic [7:0] ADDR_STATUS  = 8'h04;
    localparam logic [7:0] ADDR_BONDCH  = 8'h08;
    localparam logic [7:0] ADDR_CRC_TX  = 8'h0C;
    localparam logic [7:0] ADDR_CRC_RX  = 8'h10;
    localparam logic [7:0] ADDR_CCHAR   = 8'h14;
    // control field positions
    localparam int CTRL_LOOP_LSB  = 0;   // 3 bits loopback select
    localparam int CTRL_WIDTH_LSB = 3;   // 2 bits fabric width
    localparam int CTRL_MASTER    = 5;
    localparam int CTRL_BOND_GO   = 6;   // write one: arm bond, runs once lane 0 mark sits mid-buffer
    localparam int CTRL_OFS_LSB   = 8;   // 2 bits bond offset
    localparam int CTRL_FLAG_CLR  = 12;  // write one: clear sticky flags
    localparam logic [31:0] CTRL_RESET   = 32'h0000_0008;
    localparam logic [7:0]  BOND_RESET   = 8'hBC;
    localparam logic [7:0]  CCHAR_RESET  = 8'h1C;
    localparam logic [15:0] CRC_SEED     = 16'hFFFF;
    localparam logic [15:0] CRC_POLY     = 16'h1021;
    // path reset release delay in cycles
    localparam int RST_RELEASE_CYC = 5;
    localparam int TXF_DEPTH       = 4;
    localparam int RXB_DEPTH       = 16;
    // loopback modes
    typedef enum logic [2:0] {
        LOOP_NONE, LOOP_SER_PRE, LOOP_SER_POST, LOOP_PARALLEL, LOOP_REPEAT
    } loop_t;
    // fabric width codes
    localparam logic [1:0] WIDTH_1B = 2'h0;
    localparam logic [1:0] WIDTH_2B = 2'h1;
    localparam logic [1:0] WIDTH_4B = 2'h2;
endpackage

/* File: design/path_reset_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module path_reset_gen
    import lane_pkg::*;
(
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic path_reset_pin,
    output logic      in_reset
);
    typedef struct packed {
        logic [2:0] sync;
        logic [2:0] cnt;
        logic       hold;
    } rst_st_t;
    rst_st_t st_ff;
    rst_st_t nxt_st;
    // sync pin then hold reset five cycles after the two late stages agree low
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sync = {st_ff.sync[1:0], path_reset_pin};
        if (st_ff.sync[2] && st_ff.sync[1]) begin
            nxt_st.hold = 1'b1;
            nxt_st.cnt  = 3'(RST_RELEASE_CYC);
        end else if (st_ff.hold && !st_ff.sync[2] && !st_ff.sync[1]) begin
            if (st_ff.cnt <= 3'h1) begin
                nxt_st.hold = 1'b0;
                nxt_st.cnt  = 3'h0;
            end else begin
                nxt_st.cnt = st_ff.cnt - 3'h1;
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff <= '{sync: 3'h0, cnt: 3'h0, hold: 1'b1};
        end else begin
            st_ff <= nxt_st;
        end
    end
    assign in_reset = st_ff.hold;
endmodule
`default_nettype wire

/* File: design/serdes_lane_pcs.sv */
// Design decisions made here: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - each lane records where the bonding character sits.
// - master moves all read positions to mark plus offset.
// - after bonding, master decides all repeats and skips.
// - low buffer repeats a sequence; high buffer skips one.
// - transmit buffer absorbs phase only.
// - transmit FIFO four deep, flags overflow and underflow.
// - four loopbacks: pre-driver, post-driver, parallel, repeater.
// - pre-driver loopback leaves serial outputs undriven.
// - post-driver loopback keeps serial outputs driven.
// - parallel loopback bypasses serial path; transmitter still sends.
// - inhibit holds positive serial output low.
// - repeater loopback resends received data past the fabric.
// - transmit reset recenters FIFO, clears transmit state.
// - receive reset recenters elastic buffer, clears receive state.
// - each path reset holds only its own path of the coding sublayer in reset.
// - reset ends five cycles after the synchronized path reset release.
// - path resets leave media-attachment settings untouched.
// - sleep input powers lane down; package pin ignored.
// - fabric transmit path is 1, 2 or 4 bytes wide; lane receive word stays 4 bytes.
// - CRC made on transmit outside repeater loopback, and made on receive; nothing compares it.
module serdes_lane_pcs
    import lane_pkg::*;
#(
    parameter int NLANES = 4
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    input  wire logic [7:0]        s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [7:0]        s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    input  wire logic              tx_path_reset,
    input  wire logic              rx_path_reset,
    input  wire logic              tx_output_inhibit,
    input  wire logic              lane_sleep,
    input  wire logic [31:0]       tx_data,
    input  wire logic              tx_valid,
    output logic [31:0]            rx_data,
    output logic                   rx_valid,
    input  wire logic [8*NLANES-1:0] lane_rx_bytes,
    input  wire logic              lane_rx_valid,
    output logic [7:0]             serial_out_byte,
    output logic                   serial_out_pos,
    output logic                   serial_out_neg,
    output logic                   serial_out_oe,
    output logic [NLANES-1:0]      bond_found,
    output logic                   lane_aligned
);
    localparam int BW = $clog2(RXB_DEPTH);
    typedef struct packed {
        logic           awdone;
        logic           wdone;
        logic [7:0]     awaddr;
        logic [31:0]    wdata;
        logic           bvalid;
        logic           rvalid;
        logic [31:0]    rdata;
        logic [1:0]     bresp;
        logic [1:0]     rresp;
        logic [31:0]    ctrl;
        logic [7:0]     bond_char;
        logic [7:0]     cc_char;
        logic           bond_go;
        logic           aligned;
        logic [NLANES-1:0][BW-1:0] mark;
        logic [NLANES-1:0][BW-1:0] skew;
        logic [NLANES-1:0] found;
        logic [BW-1:0]  wp;
        logic [BW-1:0]  rp;
        logic [15:0]    crc_tx;
        logic [15:0]    crc_rx;
        logic           ovf_flag;
        logic           unf_flag;
        logic [1:0]     cc_last;   // 1 repeat, 2 skip
        logic [31:0]    rx_out;
        logic           rx_vld;
        logic [7:0]     ser_byte;
        logic           ser_pos;
        logic           ser_neg;
        logic           ser_oe;
        logic [1:0]     phase;
    } pcs_st_t;
    pcs_st_t st_ff;
    pcs_st_t nxt_st;
    logic [8*NLANES-1:0] rxbuf [RXB_DEPTH];
    logic tx_rst;
    logic rx_rst;
    logic fifo_rd;
    logic [31:0] fifo_q;
    logic ovf;
    logic unf;
    loop_t loop_mode;
    logic [BW-1:0] level;
    logic [8*NLANES-1:0] rd_word;
    logic [7:0] lane0_byte;
    logic [2:0] nbytes;
    logic [31:0] masked;

    // one CRC-16 step over a byte
    function automatic logic [15:0] crc_step(input logic [15:0] c,
                                             input logic [7:0]  d);
        logic [15:0] r;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            r = (r[15] ^ d[i]) ? ((r << 1) ^ CRC_POLY) : (r << 1);
        end
        return r;
    endfunction

    // number of fabric bytes for a width code
    function automatic logic [2:0] width_bytes(input logic [1:0] w);
        unique case (w)
            WIDTH_1B: width_bytes = 3'h1;
            WIDTH_2B: width_bytes = 3'h2;
            default:  width_bytes = 3'h4;
        endcase
    endfunction

    path_reset_gen u_txrst (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .path_reset_pin (tx_path_reset),
        .in_reset       (tx_rst)
    );
    path_reset_gen u_rxrst (
        .aclk           (aclk),
        .aresetn        (aresetn),
        .path_reset_pin (rx_path_reset),
        .in_reset       (rx_rst)
    );
    tx_phase_fifo #(.WIDTH(32), .DEPTH(TXF_DEPTH)) u_txf (
        .aclk      (aclk),
        .clear     (tx_rst || !aresetn),
        .wr_en     (tx_valid && !tx_rst && !lane_sleep),
        .wr_data   (tx_data),
        .rd_en     (fifo_rd),
        .rd_data   (fifo_q),
        .overflow  (ovf),
        .underflow (unf)
    );

    // loopback decode, illegal codes fall back to normal
    always_comb begin
        unique case (st_ff.ctrl[CTRL_LOOP_LSB +: 3])
            3'h1:    loop_mode = LOOP_SER_PRE;
            3'h2:    loop_mode = LOOP_SER_POST;
            3'h3:    loop_mode = LOOP_PARALLEL;
            3'h4:    loop_mode = LOOP_REPEAT;
            default: loop_mode = LOOP_NONE;
        endcase
    end

    // fabric width, buffer level, read word
    assign nbytes     = width_bytes(st_ff.ctrl[CTRL_WIDTH_LSB +: 2]);
    assign level      = st_ff.wp - st_ff.rp;
    assign lane0_byte = rd_word[7:0];
    assign fifo_rd    = !tx_rst && !lane_sleep && st_ff.phase == 2'h0;
    assign masked     = (nbytes == 3'h1) ? {24'h0, fifo_q[7:0]} :
                        (nbytes == 3'h2) ? {16'h0, fifo_q[15:0]} : fifo_q;
    // each lane reads at the common pointer plus its bonded skew
    for (genvar g = 0; g < NLANES; g++) begin : g_lane
        assign rd_word[8*g +: 8] = rxbuf[BW'(st_ff.rp + st_ff.skew[g])][8*g +: 8];
    end

    // main next-state logic
    always_comb begin
        nxt_st = st_ff;
        // bus write: address and data in either order
        if (s_axi_awvalid && !st_ff.awdone) begin
            nxt_st.awdone = 1'b1;
            nxt_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !st_ff.wdone) begin
            nxt_st.wdone = 1'b1;
            nxt_st.wdata = s_axi_wdata;
        end
        if (st_ff.awdone && st_ff.wdone && !st_ff.bvalid) begin
            nxt_st.awdone = 1'b0;
            nxt_st.wdone  = 1'b0;
            nxt_st.bvalid = 1'b1;
            nxt_st.bresp  = 2'b00;
            unique case (st_ff.awaddr)
                ADDR_CTRL: begin
                    nxt_st.ctrl    = st_ff.wdata;
                    nxt_st.bond_go = st_ff.wdata[CTRL_BOND_GO];
                    if (st_ff.wdata[CTRL_FLAG_CLR]) begin
                        nxt_st.ovf_flag = 1'b0;
                        nxt_st.unf_flag = 1'b0;
                    end
                end
                ADDR_BONDCH: nxt_st.bond_char = st_ff.wdata[7:0];
                ADDR_CCHAR:  nxt_st.cc_char   = st_ff.wdata[7:0];
                default:     nxt_st.bresp     = 2'b10;
            endcase
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        // bus read
        if (s_axi_arvalid && !st_ff.rvalid) begin
            nxt_st.rvalid = 1'b1;
            nxt_st.rresp  = 2'b00;
            unique case (s_axi_araddr)
                ADDR_CTRL:   nxt_st.rdata = st_ff.ctrl;
                ADDR_STATUS: nxt_st.rdata = 32'({st_ff.cc_last,
                    st_ff.found, st_ff.aligned,
                    st_ff.unf_flag, st_ff.ovf_flag});
                ADDR_BONDCH: nxt_st.rdata = {24'h0, st_ff.bond_char};
                ADDR_CRC_TX: nxt_st.rdata = {16'h0, st_ff.crc_tx};
                ADDR_CRC_RX: nxt_st.rdata = {16'h0, st_ff.crc_rx};
                ADDR_CCHAR:  nxt_st.rdata = {24'h0, st_ff.cc_char};
                default: begin
                    nxt_st.rdata = 32'h0000_0000;
                    nxt_st.rresp = 2'b10;
                end
            endcase
        end else if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end

        // transmit: one byte per cycle
        nxt_st.phase = st_ff.phase + 2'h1;
        if (st_ff.phase == 2'(nbytes - 3'h1)) begin
            nxt_st.phase = 2'h0;
        end
        if (ovf) begin
            nxt_st.ovf_flag = 1'b1;
        end
        if (unf) begin
            nxt_st.unf_flag = 1'b1;
        end
        if (loop_mode == LOOP_REPEAT) begin
            nxt_st.ser_byte = lane0_byte;
        end else begin
            nxt_st.ser_byte = masked[8*st_ff.phase +: 8];
            nxt_st.crc_tx   = crc_step(st_ff.crc_tx,
                                       masked[8*st_ff.phase +: 8]);
        end
        nxt_st.ser_pos = ^nxt_st.ser_byte;
        nxt_st.ser_neg = ~nxt_st.ser_pos;
        nxt_st.ser_oe  = (loop_mode != LOOP_SER_PRE);
        if (tx_output_inhibit) begin
            nxt_st.ser_pos = 1'b0;
        end
        if (tx_rst) begin
            nxt_st.crc_tx   = CRC_SEED;
            nxt_st.ser_byte = 8'h00;
            nxt_st.ser_pos  = 1'b0;
            nxt_st.ser_neg  = 1'b0;
            nxt_st.phase    = 2'h0;
        end

        // receive: store lanes, find bonding char
        if (lane_rx_valid) begin
            nxt_st.wp = st_ff.wp + BW'(1);
        end
        for (int l = 0; l < NLANES; l++) begin
            if (lane_rx_valid && lane_rx_bytes[8*l +: 8] == st_ff.bond_char) begin
                nxt_st.mark[l]  = st_ff.wp;
                nxt_st.found[l] = 1'b1;
            end
        end
        nxt_st.rp = st_ff.rp + BW'(1);
        nxt_st.cc_last = 2'h0;
        // pending bond runs once lane 0 mark sits mid-buffer
        if (st_ff.ctrl[CTRL_MASTER] && st_ff.bond_go && &st_ff.found
            && BW'(st_ff.wp - st_ff.mark[0]) == BW'(RXB_DEPTH / 2)) begin
            nxt_st.rp = st_ff.mark[0] + BW'(st_ff.ctrl[CTRL_OFS_LSB +: 2]);
            nxt_st.aligned = 1'b1;
            nxt_st.bond_go = 1'b0;
            for (int l = 0; l < NLANES; l++) begin
                nxt_st.skew[l] = st_ff.mark[l] - st_ff.mark[0];
            end
        end else if (lane0_byte == st_ff.cc_char
                     && (st_ff.ctrl[CTRL_MASTER] || !st_ff.aligned)) begin
            // one correction decision drives the common read pointer
            if (level < BW'(RXB_DEPTH / 4)) begin
                nxt_st.rp = st_ff.rp;
                nxt_st.cc_last = 2'h1;
            end else if (level > BW'(3 * RXB_DEPTH / 4)) begin
                nxt_st.rp = st_ff.rp + BW'(2);
                nxt_st.cc_last = 2'h2;
            end
        end
        // receive source per loopback
        if (loop_mode == LOOP_PARALLEL) begin
            nxt_st.rx_out = masked;
        end else if (loop_mode == LOOP_SER_PRE || loop_mode == LOOP_SER_POST) begin
            nxt_st.rx_out = {24'h0, st_ff.ser_byte};
        end else begin
            nxt_st.rx_out = rd_word[31:0];
        end
        nxt_st.rx_vld = !lane_sleep;
        nxt_st.crc_rx = crc_step(st_ff.crc_rx, nxt_st.rx_out[7:0]);
        if (rx_rst) begin
            nxt_st.wp      = BW'(RXB_DEPTH / 2);
            nxt_st.rp      = '0;
            nxt_st.found   = '0;
            nxt_st.skew    = '0;
            nxt_st.aligned = 1'b0;
            nxt_st.crc_rx  = CRC_SEED;
            nxt_st.rx_out  = 32'h0000_0000;
            nxt_st.rx_vld  = 1'b0;
            nxt_st.cc_last = 2'h0;
        end
        // sleep quiets outputs
        if (lane_sleep) begin
            nxt_st.ser_oe  = 1'b0;
            nxt_st.ser_pos = 1'b0;
            nxt_st.ser_neg = 1'b0;
        end
    end

    // state register and elastic buffer store
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_ff           <= '0;
            st_ff.ctrl      <= CTRL_RESET;
            st_ff.bond_char <= BOND_RESET;
            st_ff.cc_char   <= CCHAR_RESET;
            st_ff.crc_tx    <= CRC_SEED;
            st_ff.crc_rx    <= CRC_SEED;
            st_ff.wp        <= BW'(RXB_DEPTH / 2);
        end else begin
            st_ff <= nxt_st;
        end
        if (lane_rx_valid) begin
            rxbuf[st_ff.wp] <= lane_rx_bytes;
        end
    end

    // outputs from flops
    assign s_axi_awready   = !st_ff.awdone;
    assign s_axi_wready    = !st_ff.wdone;
    assign s_axi_bvalid    = st_ff.bvalid;
    assign s_axi_bresp     = st_ff.bresp;
    assign s_axi_arready   = !st_ff.rvalid;
    assign s_axi_rvalid    = st_ff.rvalid;
    assign s_axi_rdata     = st_ff.rdata;
    assign s_axi_rresp     = st_ff.rresp;
    assign rx_data         = st_ff.rx_out;
    assign rx_valid        = st_ff.rx_vld;
    assign serial_out_byte = st_ff.ser_byte;
    assign serial_out_pos  = st_ff.ser_pos;
    assign serial_out_neg  = st_ff.ser_neg;
    assign serial_out_oe   = st_ff.ser_oe;
    assign bond_found      = st_ff.found;
    assign lane_aligned    = st_ff.aligned;
endmodule
`default_nettype wire

/* File: design/tx_phase_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module tx_phase_fifo
    import lane_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = TXF_DEPTH
) (
    input  wire logic             aclk,
    input  wire logic             clear,
    input  wire logic             wr_en,
    input  wire logic [WIDTH-1:0] wr_data,
    input  wire logic             rd_en,
    output logic [WIDTH-1:0]      rd_data,
    output logic                  overflow,
    output logic                  underflow
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   fill;
    } fifo_st_t;
    fifo_st_t st_ff;
    fifo_st_t nxt_st;
    logic [WIDTH-1:0] mem [DEPTH];
    // pointers, fill level; clear recenters to half full
    always_comb begin
        nxt_st    = st_ff;
        overflow  = 1'b0;
        underflow = 1'b0;
        if (clear) begin
            nxt_st.wp   = AW'(DEPTH / 2);
            nxt_st.rp   = '0;
            nxt_st.fill = (AW+1)'(DEPTH / 2);
        end else begin
            if (wr_en) begin
                nxt_st.wp = st_ff.wp + AW'(1);
            end
            if (rd_en) begin
                nxt_st.rp = st_ff.rp + AW'(1);
            end
            // overflow on write when full, underflow on read when empty
            overflow  = wr_en && !rd_en && (st_ff.fill == (AW+1)'(DEPTH));
            underflow = rd_en && !wr_en && (st_ff.fill == '0);
            if (wr_en && !rd_en && !overflow) begin
                nxt_st.fill = st_ff.fill + (AW+1)'(1);
            end else if (rd_en && !wr_en && !underflow) begin
                nxt_st.fill = st_ff.fill - (AW+1)'(1);
            end
        end
    end
    always_ff @(posedge aclk) begin
        st_ff <= nxt_st;
        if (wr_en) begin
            mem[st_ff.wp] <= wr_data;
        end
    end
    assign rd_data = mem[st_ff.rp];
endmodule
`default_nettype wire
